// ===== pir_line_steer.sv
`timescale 1ns/1ns
package pir_pkg;
  localparam int NUM_LINES = 8;
  localparam int LEGACY_IRQS = 16;
  localparam int ADV_IRQS = 24;
  localparam int ADV_BASE = 16;
  localparam int STEER_W = 4;
  localparam int SLOT_INTS = 4;
  localparam int NUM_SLOTS = 5;
  localparam logic [3:0] CASCADE_IRQ = 4'h2;
  // IRQs 3-7, 9-12, 14, 15 may take a shared line in legacy mode
  localparam logic [15:0] LEGACY_ALLOWED = 16'hDEF8;
  localparam logic [23:0] IRQ_RESET = 24'h000000;
  localparam logic [7:0] LINE_RESET = 8'h00;
  // Line indices
  localparam int LINE_A = 0;
  localparam int LINE_B = 1;
  localparam int LINE_C = 2;
  localparam int LINE_D = 3;
  localparam int LINE_E = 4;
  localparam int LINE_F = 5;
  localparam int LINE_G = 6;
  localparam int LINE_H = 7;
  // Slot pin indices
  localparam int INT_A = 0;
  localparam int INT_B = 1;
  localparam int INT_C = 2;
  localparam int INT_D = 3;
  // Quiet time on a mode change
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_NS = 8;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYCLES);

  typedef enum logic [2:0] {
    ST_LEGACY = 3'b001,
    ST_SWITCH = 3'b010,
    ST_ADVANCED = 3'b100
  } pir_mode_t;

  function automatic logic pir_sel_valid(input logic [3:0] sel);
    pir_sel_valid = LEGACY_ALLOWED[sel] && (sel != CASCADE_IRQ);
  endfunction
endpackage

module pir_line_steer (
  // Request and setting
  input wire logic line_req_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_sel_i,
  input wire logic legacy_en_i,
  // Result
  output logic [pir_pkg::LEGACY_IRQS-1:0] irq_vec_o,
  output logic sel_valid_o
);
  import pir_pkg::*;

  always_comb begin
    sel_valid_o = pir_sel_valid(steer_sel_i);
    irq_vec_o = '0;
    // Only an allowed IRQ is ever reached; the cascade input stays free
    if (legacy_en_i && line_req_i && sel_valid_o) begin
      irq_vec_o[steer_sel_i] = 1'b1;
    end
  end
endmodule

// ===== pir_router.sv
`timescale 1ns/1ns
module pir_router (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Mode select, high for advanced controller mode
  input wire logic adv_mode_i,
  // Legacy steering settings, one per shared line
  input wire logic [pir_pkg::STEER_W-1:0] steer_a_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_b_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_c_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_d_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_e_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_f_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_g_i,
  input wire logic [pir_pkg::STEER_W-1:0] steer_h_i,
  // Onboard sources, active low levels
  input wire logic agp_inta_n_i,
  input wire logic agp_intb_n_i,
  input wire logic usb1_int_n_i,
  input wire logic usb2_int_n_i,
  input wire logic usb3_int_n_i,
  input wire logic ehci_int_n_i,
  input wire logic smbus_int_n_i,
  input wire logic audio_int_n_i,
  input wire logic lan_int_n_i,
  input wire logic raid_int_n_i,
  input wire logic ieee1394_int_n_i,
  // Slot pins, bit 0 is INTA through bit 3 INTD, active low
  input wire logic [pir_pkg::SLOT_INTS-1:0] slot1_int_n_i,
  input wire logic [pir_pkg::SLOT_INTS-1:0] slot2_int_n_i,
  input wire logic [pir_pkg::SLOT_INTS-1:0] slot3_int_n_i,
  input wire logic [pir_pkg::SLOT_INTS-1:0] slot4_int_n_i,
  input wire logic [pir_pkg::SLOT_INTS-1:0] slot5_int_n_i,
  // Controller side
  output logic [pir_pkg::ADV_IRQS-1:0] irq_o,
  output logic [pir_pkg::NUM_LINES-1:0] shared_line_o,
  output logic [pir_pkg::NUM_LINES-1:0] steer_invalid_o,
  output logic adv_mode_o,
  output logic switching_o
);
  import pir_pkg::*;

  pir_mode_t state_r;
  pir_mode_t state_nxt;
  logic [3:0] settle_r;
  logic [3:0] settle_nxt;
  logic [NUM_LINES-1:0] line_req;
  logic [STEER_W-1:0] steer [NUM_LINES];
  logic [LEGACY_IRQS-1:0] line_vec [NUM_LINES];
  logic [NUM_LINES-1:0] sel_valid;
  logic [LEGACY_IRQS-1:0] legacy_irq;
  logic [ADV_IRQS-1:0] irq_nxt;
  logic legacy_en;

  // Shared lines are the wired-OR of their active-low sources. The
  // sources keep their level until serviced, so no latching here.
  always_comb begin
    line_req[LINE_A] = !usb1_int_n_i
                       || !agp_inta_n_i
                       || !slot3_int_n_i[INT_D]
                       || !slot5_int_n_i[INT_C];
    line_req[LINE_B] = !audio_int_n_i
                       || !agp_intb_n_i
                       || !smbus_int_n_i
                       || !ieee1394_int_n_i
                       || !slot3_int_n_i[INT_C]
                       || !slot5_int_n_i[INT_A];
    line_req[LINE_C] = !usb3_int_n_i
                       || !slot3_int_n_i[INT_A]
                       || !slot4_int_n_i[INT_B];
    line_req[LINE_D] = !usb2_int_n_i
                       || !slot3_int_n_i[INT_B]
                       || !slot4_int_n_i[INT_A];
    line_req[LINE_E] = !lan_int_n_i
                       || !slot1_int_n_i[INT_D]
                       || !slot2_int_n_i[INT_C]
                       || !slot5_int_n_i[INT_D];
    // G carries slot sources only; F carries slot sources and the onboard RAID source
    line_req[LINE_F] = !slot1_int_n_i[INT_A]
                       || !slot2_int_n_i[INT_B]
                       || !slot4_int_n_i[INT_C]
                       || !raid_int_n_i;
    line_req[LINE_G] = !slot1_int_n_i[INT_B]
                       || !slot2_int_n_i[INT_A]
                       || !slot4_int_n_i[INT_D];
    line_req[LINE_H] = !ehci_int_n_i
                       || !slot1_int_n_i[INT_C]
                       || !slot2_int_n_i[INT_D]
                       || !slot5_int_n_i[INT_B];
  end

  always_comb begin
    steer[LINE_A] = steer_a_i;
    steer[LINE_B] = steer_b_i;
    steer[LINE_C] = steer_c_i;
    steer[LINE_D] = steer_d_i;
    steer[LINE_E] = steer_e_i;
    steer[LINE_F] = steer_f_i;
    steer[LINE_G] = steer_g_i;
    steer[LINE_H] = steer_h_i;
  end

  // Keyed on the next state so that irq_o turns in the same cycle as
  // adv_mode_o and switching_o; a request never lingers into the switch.
  assign legacy_en = (state_nxt == ST_LEGACY);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      pir_line_steer u_steer (
        .line_req_i(line_req[gi]),
        .steer_sel_i(steer[gi]),
        .legacy_en_i(legacy_en),
        .irq_vec_o(line_vec[gi]),
        .sel_valid_o(sel_valid[gi])
      );
    end
  endgenerate

  // OR rather than a priority pick, so two lines on one IRQ both count
  always_comb begin
    legacy_irq = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      legacy_irq = legacy_irq | line_vec[i];
    end
  end

  always_comb begin
    irq_nxt = IRQ_RESET;
    case (state_nxt)
      ST_LEGACY: begin
        irq_nxt[LEGACY_IRQS-1:0] = legacy_irq;
      end
      ST_ADVANCED: begin
        irq_nxt[ADV_IRQS-1:ADV_BASE] = line_req;
      end
      default: begin
        irq_nxt = IRQ_RESET;
      end
    endcase
  end

  // Mode changes pass through a short quiet state so that no
  // request shows on both the legacy and advanced inputs at once.
  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
      ST_LEGACY: begin
        if (adv_mode_i) begin
          state_nxt = ST_SWITCH;
          settle_nxt = SETTLE_CNT;
        end
      end
      ST_ADVANCED: begin
        if (!adv_mode_i) begin
          state_nxt = ST_SWITCH;
          settle_nxt = SETTLE_CNT;
        end
      end
      ST_SWITCH: begin
        if (settle_r > 4'h1) begin
          settle_nxt = settle_r - 4'h1;
        end else begin
          settle_nxt = 4'h0;
          state_nxt = adv_mode_i ? ST_ADVANCED : ST_LEGACY;
        end
      end
      default: begin
        state_nxt = ST_LEGACY;
        settle_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_r <= ST_LEGACY;
      settle_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      irq_o <= IRQ_RESET;
      shared_line_o <= LINE_RESET;
    end else begin
      irq_o <= irq_nxt;
      shared_line_o <= line_req;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      steer_invalid_o <= LINE_RESET;
      adv_mode_o <= 1'b0;
      switching_o <= 1'b0;
    end else begin
      steer_invalid_o <= ~sel_valid;
      adv_mode_o <= (state_nxt == ST_ADVANCED);
      switching_o <= (state_nxt == ST_SWITCH);
    end
  end
endmodule

// ===== pir_router_sva.sv
`timescale 1ns/1ns
module pir_router_sva (
  // Clock, reset and inputs
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic usb1_int_n_i,
  input wire logic [3:0] steer_a_i,
  // Controller side
  input wire logic [23:0] irq_o,
  input wire logic [7:0] shared_line_o,
  input wire logic [7:0] steer_invalid_o,
  input wire logic adv_mode_o,
  input wire logic switching_o
);
  import pir_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_quiet;
    switching_o [*2] ##1 !switching_o;
  endsequence
  a_switch_len: assert property ($rose(switching_o) |-> s_quiet)
    else $error("switch length");
  a_legacy_top: assert property (!adv_mode_o |-> !irq_o[23:16])
    else $error("upper irq in legacy");
  a_adv_low: assert property (adv_mode_o |-> !irq_o[15:0])
    else $error("lower irq in advanced");
  a_adv_lines: assert property (adv_mode_o |->
    irq_o[23:16] == shared_line_o)
    else $error("advanced irq off line");
  a_no_reserved: assert property (!(irq_o[15:0] & ~LEGACY_ALLOWED))
    else $error("reserved irq raised");
  a_usb1_line: assert property (!usb1_int_n_i |=>
    shared_line_o[LINE_A])
    else $error("line a missed");
  a_steer_hit: assert property (!adv_mode_o && !switching_o &&
    shared_line_o[0] && !steer_invalid_o[0] |-> irq_o[$past(steer_a_i)])
    else $error("steered irq missing");
  a_invalid_flag: assert property ($past(resetn_i) |->
    steer_invalid_o[0] == !LEGACY_ALLOWED[$past(steer_a_i)])
    else $error("invalid flag wrong");
endmodule
bind pir_router pir_router_sva u_sva (
  .core_clk_i(core_clk_i),
  .resetn_i(resetn_i),
  .usb1_int_n_i(usb1_int_n_i),
  .steer_a_i(steer_a_i),
  .irq_o(irq_o),
  .shared_line_o(shared_line_o),
  .steer_invalid_o(steer_invalid_o),
  .adv_mode_o(adv_mode_o),
  .switching_o(switching_o)
);

// ===== pir_src_model.sv
`timescale 1ns/1ns
module pir_src_model #(
  parameter int W = 31
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Strobes and wired levels
  input wire logic [W-1:0] raise_i,
  input wire logic [W-1:0] service_i,
  output logic [W-1:0] int_n_o
);
  // Released lines sit at the pull-up level
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      int_n_o <= '1;
    end else begin
      int_n_o <= (int_n_o & ~raise_i) | service_i;
    end
  end
endmodule

// ===== pir_interrupt_request_router_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t mismatch", $time); end end
module pci_interrupt_request_router_tb_top;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic adv_mode_i = 1'b0;
  logic [7:0][3:0] st = {8{4'h3}};
  logic [30:0] raise = '0;
  logic [30:0] service = '0;
  logic [30:0] s;
  logic [23:0] irq;
  logic [7:0] line;
  logic [7:0] inv;
  logic advo;
  logic sw;
  int bad_count = 0;
  int checked = 0;
  // Line of each source: onboard first, then slot pins
  int map [31] = '{0, 1, 0, 3, 2, 7, 1, 1, 4, 5, 1, 5, 6, 7, 4, 6, 5, 4, 7,
    2, 3, 1, 0, 3, 2, 5, 6, 1, 7, 0, 4};
  initial forever #2 core_clk_i = ~core_clk_i;
  pir_src_model #(.W(31)) src_mdl (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .raise_i(raise), .service_i(service), .int_n_o(s));
  pir_router dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .adv_mode_i(adv_mode_i), .steer_a_i(st[0]), .steer_b_i(st[1]),
    .steer_c_i(st[2]), .steer_d_i(st[3]), .steer_e_i(st[4]),
    .steer_f_i(st[5]), .steer_g_i(st[6]), .steer_h_i(st[7]),
    .agp_inta_n_i(s[0]), .agp_intb_n_i(s[1]), .usb1_int_n_i(s[2]),
    .usb2_int_n_i(s[3]), .usb3_int_n_i(s[4]), .ehci_int_n_i(s[5]),
    .smbus_int_n_i(s[6]), .audio_int_n_i(s[7]), .lan_int_n_i(s[8]),
    .raid_int_n_i(s[9]), .ieee1394_int_n_i(s[10]),
    .slot1_int_n_i(s[14:11]), .slot2_int_n_i(s[18:15]),
    .slot3_int_n_i(s[22:19]), .slot4_int_n_i(s[26:23]),
    .slot5_int_n_i(s[30:27]), .irq_o(irq), .shared_line_o(line),
    .steer_invalid_o(inv), .adv_mode_o(advo), .switching_o(sw));
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic src(input logic [30:0] r, input logic [30:0] v);
    @(posedge core_clk_i);
    raise <= r;
    service <= v;
    @(posedge core_clk_i);
    raise <= '0;
    service <= '0;
  endtask
  task automatic t_route;
    for (int i = 0; i < 31; i++) begin
      src(31'(1) << i, '0);
      wt(2);
      `CHK(line, 8'(1) << map[i])
      `CHK(irq, adv_mode_i ? 24'(1) << (16 + map[i]) : 24'h8)
      src('0, 31'(1) << i);
    end
  endtask
  task automatic t_steer;
    logic ok;
    src(31'h4, '0);
    for (int c = 0; c < 16; c++) begin
      @(posedge core_clk_i);
      st[0] <= 4'(c);
      wt(2);
      ok = c inside {3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
      `CHK(inv[0], !ok)
      `CHK(irq, ok ? 24'(1) << c : 24'h0)
    end
    src('0, 31'h4);
  endtask
  task automatic t_share;
    @(posedge core_clk_i);
    st[0] <= 4'h9;
    st[2] <= 4'h9;
    src(31'h80014, '0);
    src('0, 31'h4);
    wt(2);
    `CHK(irq, 24'h200)
    src('0, 31'h10);
    wt(2);
    `CHK(line, 8'h4)
    src('0, 31'h80000);
    wt(2);
    `CHK(irq, 24'h0)
  endtask
  task automatic t_mode(input logic v);
    // Line A stays raised across the switch so the quiet time shows
    src(31'h4, '0);
    @(posedge core_clk_i);
    adv_mode_i <= v;
    wt(1);
    `CHK({sw, irq}, {1'b1, 24'h0})
    wt(2);
    `CHK({advo, sw}, {v, 1'b0})
    `CHK(irq, v ? 24'h010000 : 24'h000200)
    src('0, 31'h4);
  endtask
  task automatic finish_test;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_route();
    t_steer();
    t_share();
    t_mode(1'b1);
    t_route();
    t_mode(1'b0);
    finish_test();
  end
endmodule
